/* File: verilog/pqs_quick_status.sv */
// quick-status register of the embedded phy, core clock side
//
// Summary of operation
// - receive error at fast speed sets bit 15 until the register is read
// - config zero: bit 14 is false carrier at fast speed, held until read
// - config one: bit 14 flags any change of the link status bit
// - remote fault sets bit 13 until the register is read
// - fast speed: descrambler unlock sets bit 12 until read
// - slow speed: jabber sets bit 12 until read
// - link bit latches low on failure and stays low until read
// - partner pause bit follows the partner's flow control wish
// - speed bit is one at fast speed, zero at slow speed
// - duplex bit is one for full duplex, zero for half
// - config zero, unmasked: interrupt on bits 15..12 rising or link falling
// - config one: interrupt only on link change; config bit writable, resets zero
// - mask high blocks every interrupt; low lets config choose
// - low field holds lowest negotiation state since last read
// - negotiation states are ranked by their three-bit codes
// - high field holds highest negotiation state since last read
`timescale 1ns/100ps
`default_nettype none
module pqs_quick_status
    import pqs_pkg::*;
(
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic mgmtClk,
    input wire logic mdioIn,
    output logic mdioOut,
    output logic mdioOeN,
    input wire logic rxErrEv,
    input wire logic falseCarrierEv,
    input wire logic remoteFaultEv,
    input wire logic unlockEv,
    input wire logic jabberEv,
    input wire logic linkValid,
    input wire logic partnerPause,
    input wire logic fastSpeed,
    input wire logic fullDuplex,
    input wire logic [2:0] anegState,
    output logic statusIrq
);
    // ---------------------------------------------------------------
    // state
    // ---------------------------------------------------------------
    typedef struct packed {
        logic [1:0] rdSync;
        logic rdSeen;
        logic [1:0] wrSync;
        logic wrSeen;
        logic [1:0] ackSync;
        logic rxErr;
        logic fc;
        logic lc;
        logic remF;
        logic unlk;
        logic linkLat;
        logic pause;
        logic speed;
        logic dup;
        logic conf;
        logic mask;
        logic [2:0] low;
        logic [2:0] high;
        logic [15:0] pub;
        logic pubTgl;
        pqs_pub_e pubSt;
        logic irq;
    } pqs_core_s;

    localparam pqs_core_s CORE_RST = '{
        pubSt: PUB_LOAD,
        conf: CONF_RST,
        mask: MASK_RST,
        low: ANEG_RST,
        high: ANEG_RST,
        default: '0
    };

    pqs_core_s q;
    pqs_core_s d;
    logic [15:0] regVal;
    logic rdPulse;
    logic wrPulse;
    logic cause;

    pqs_mgmt_if mif ();

    // ---------------------------------------------------------------
    // management clock side
    // ---------------------------------------------------------------
    pqs_mdio_slave u_slave (
        .mgmtClk(mgmtClk),
        .sys_rst(sys_rst),
        .mdioIn(mdioIn),
        .mdioOut(mdioOut),
        .mdioOeN(mdioOeN),
        .m(mif.mgmt)
    );

    // ---------------------------------------------------------------
    // register image
    // ---------------------------------------------------------------
    always_comb begin
        regVal = '0;
        regVal[BIT_RXERR] = q.rxErr;
        regVal[BIT_B14] = q.conf ? q.lc : q.fc;
        regVal[BIT_REMF] = q.remF;
        regVal[BIT_UNLK] = q.unlk;
        regVal[BIT_LINK] = q.linkLat;
        regVal[BIT_PAUSE] = q.pause;
        regVal[BIT_SPEED] = q.speed;
        regVal[BIT_DUP] = q.dup;
        regVal[BIT_CONF] = q.conf;
        regVal[BIT_MASK] = q.mask;
        regVal[LOW_LSB +: 3] = q.low;
        regVal[HIGH_LSB +: 3] = q.high;
    end

    assign rdPulse = q.rdSync[1] ^ q.rdSeen;
    assign wrPulse = q.wrSync[1] ^ q.wrSeen;

    // ---------------------------------------------------------------
    // next state
    // ---------------------------------------------------------------
    always_comb begin
        d = q;
        d.rdSync = {q.rdSync[0], mif.rdTgl};
        d.wrSync = {q.wrSync[0], mif.wrTgl};
        d.ackSync = {q.ackSync[0], mif.pubAck};
        d.rdSeen = q.rdSync[1];
        d.wrSeen = q.wrSync[1];

        // sticky flags: a new event wins over the read clear
        // receive error, false carrier, remote fault, unlock or jabber
        d.rxErr = (q.rxErr & ~rdPulse) | (rxErrEv & fastSpeed);
        d.fc = (q.fc & ~rdPulse) | (falseCarrierEv & fastSpeed & ~q.conf);
        d.remF = (q.remF & ~rdPulse) | remoteFaultEv;
        d.unlk = (q.unlk & ~rdPulse) | (fastSpeed ? unlockEv : jabberEv);

        if (rdPulse) begin
            d.linkLat = linkValid;
        end else begin
            d.linkLat = q.linkLat & linkValid;
        end

        d.lc = (q.lc & ~rdPulse) | (d.linkLat != q.linkLat);

        d.pause = partnerPause;
        d.speed = fastSpeed;
        d.dup = fullDuplex;

        if (rdPulse) begin
            d.low = anegState;
            d.high = anegState;
        end else begin
            if (anegState < q.low) begin
                d.low = anegState;
            end
            if (anegState > q.high) begin
                d.high = anegState;
            end
        end

        if (wrPulse) begin
            d.conf = mif.wrData[BIT_CONF];
            d.mask = mif.wrData[BIT_MASK];
        end

        if (q.conf) begin
            cause = d.lc & ~q.lc;
        end else begin
            cause = (d.rxErr & ~q.rxErr) | (d.fc & ~q.fc)
                | (d.remF & ~q.remF) | (d.unlk & ~q.unlk)
                | (q.linkLat & ~d.linkLat);
        end
        d.irq = ~q.mask & ((q.irq & ~rdPulse) | cause);

        // continuous snapshot publish to the management clock
        case (q.pubSt)
            PUB_LOAD: begin
                d.pub = regVal;
                d.pubTgl = ~q.pubTgl;
                d.pubSt = PUB_WAIT;
            end
            PUB_WAIT: begin
                if (q.ackSync[1] == q.pubTgl) begin
                    d.pubSt = PUB_LOAD;
                end
            end
            default: d.pubSt = PUB_LOAD;
        endcase
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            q <= CORE_RST;
        end else begin
            q <= d;
        end
    end

    assign mif.pubData = q.pub;
    assign mif.pubTgl = q.pubTgl;
    assign statusIrq = q.irq;

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);

    a_rx_error_set: assert property (
        rxErrEv && fastSpeed |=> q.rxErr [*2]
            or (q.rxErr ##1 $past(rdPulse))
    ) else $error("receive error not latched");

    a_false_carrier_set: assert property (
        falseCarrierEv && fastSpeed && !q.conf |=> regVal[BIT_B14] || q.conf
    ) else $error("false carrier not latched");

    a_link_change_flag: assert property (
        q.linkLat != $past(q.linkLat) |-> q.lc
    ) else $error("link change not flagged");

    a_remote_fault_set: assert property (
        remoteFaultEv |=> q.remF && regVal[BIT_REMF]
    ) else $error("remote fault not latched");

    a_unlock_fast_set: assert property (
        fastSpeed && unlockEv |=> q.unlk
    ) else $error("descrambler unlock not latched");

    a_jabber_slow_set: assert property (
        !fastSpeed && jabberEv |=> q.unlk
    ) else $error("jabber not latched");

    a_link_latch_low: assert property (
        !linkValid ##1 !rdPulse |=> !q.linkLat
    ) else $error("link bit did not hold low");

    a_live_status_bits: assert property (
        ##1 1'b1 |-> q.speed == $past(fastSpeed) && q.dup == $past(fullDuplex)
            && q.pause == $past(partnerPause)
    ) else $error("live status bits stale");

    a_irq_event_mode: assert property (
        !q.mask && !q.conf && remoteFaultEv && !q.remF |=> statusIrq
    ) else $error("event interrupt missing");

    a_irq_link_mode: assert property (
        !q.mask && q.conf && !q.lc ##1 q.lc |-> statusIrq
    ) else $error("link change interrupt missing");

    a_irq_masked_off: assert property (
        q.mask |=> !statusIrq
    ) else $error("interrupt while masked");

    a_tracker_order: assert property (
        q.low <= q.high && q.low <= $past(q.low) || $past(rdPulse)
    ) else $error("state trackers out of order");

    a_read_restart: assert property (
        rdPulse |=> q.low == $past(anegState) && q.high == $past(anegState)
            && !q.remF == !$past(remoteFaultEv)
    ) else $error("read did not restart trackers");

    a_rx_slow_ignored: assert property (
        !fastSpeed && !q.rxErr |=> !q.rxErr
    ) else $error("receive error latched at slow speed");

    a_fc_conf_blocked: assert property (
        q.conf && !q.fc |=> !q.fc
    ) else $error("false carrier latched in link change mode");

    a_irq_link_fall: assert property (
        !q.mask && !q.conf && q.linkLat && !linkValid |=> statusIrq
    ) else $error("link fall interrupt missing");

    a_irq_link_only: assert property (
        q.conf && !q.irq && !rdPulse && q.linkLat == linkValid |=> !statusIrq
    ) else $error("interrupt without link change");

    a_low_tracks_min: assert property (
        !rdPulse && anegState < q.low |=> q.low == $past(anegState)
    ) else $error("lowest state not tracked");

    a_high_tracks_max: assert property (
        !rdPulse && anegState > q.high |=> q.high == $past(anegState)
    ) else $error("highest state not tracked");
endmodule // pqs_quick_status
`default_nettype wire

/* File: verilog/pqs_pkg.sv */
// constants and types shared by the quick-status register block
package pqs_pkg;
    // ---------------------------------------------------------------
    // management frame decode
    // ---------------------------------------------------------------
    localparam logic [4:0] PHY_ADDR = 5'h10;
    localparam logic [4:0] REG_OFF = 5'h1f;
    localparam logic [1:0] OP_READ = 2'h2;
    localparam logic [1:0] OP_WRITE = 2'h1;
    localparam logic [4:0] HDR_LAST = 5'h0b;
    localparam logic [4:0] TURN_LAST = 5'h01;
    localparam logic [4:0] DATA_LAST = 5'h0f;
    // ---------------------------------------------------------------
    // register field positions
    // ---------------------------------------------------------------
    localparam int BIT_RXERR = 15;
    localparam int BIT_B14 = 14;
    localparam int BIT_REMF = 13;
    localparam int BIT_UNLK = 12;
    localparam int BIT_LINK = 11;
    localparam int BIT_PAUSE = 10;
    localparam int BIT_SPEED = 9;
    localparam int BIT_DUP = 8;
    localparam int BIT_CONF = 7;
    localparam int BIT_MASK = 6;
    localparam int LOW_LSB = 3;
    localparam int HIGH_LSB = 0;
    // ---------------------------------------------------------------
    // reset values
    // ---------------------------------------------------------------
    localparam logic CONF_RST = 1'b0;
    localparam logic MASK_RST = 1'b0;
    localparam logic [2:0] ANEG_RST = 3'h0;
    // ---------------------------------------------------------------
    // autonegotiation state codes, ranked by value
    // ---------------------------------------------------------------
    localparam logic [2:0] ANEG_ENABLE = 3'h0;
    localparam logic [2:0] ANEG_ABILITY = 3'h1;
    localparam logic [2:0] ANEG_LINK_CHECK = 3'h2;
    localparam logic [2:0] ANEG_ACK_DETECT = 3'h3;
    localparam logic [2:0] ANEG_COMPLETE_ACK = 3'h4;
    localparam logic [2:0] ANEG_GOOD_CHECK = 3'h5;
    localparam logic [2:0] ANEG_NEXT_PAGE = 3'h6;
    localparam logic [2:0] ANEG_LINK_GOOD = 3'h7;
    // ---------------------------------------------------------------
    // state machines
    // ---------------------------------------------------------------
    typedef enum logic [1:0] {MD_IDLE, MD_HDR, MD_TURN, MD_DATA} pqs_mdio_e;
    typedef enum logic {PUB_LOAD, PUB_WAIT} pqs_pub_e;
endpackage

/* File: verilog/pqs_mgmt_if.sv */
// crossing signals between management-clock and core-clock logic
`timescale 1ns/100ps
`default_nettype none
interface pqs_mgmt_if;
    logic [15:0] pubData;
    logic pubTgl;
    logic pubAck;
    logic rdTgl;
    logic wrTgl;
    logic [15:0] wrData;
    modport mgmt (
        input pubData,
        input pubTgl,
        output pubAck,
        output rdTgl,
        output wrTgl,
        output wrData
    );
    modport core (
        output pubData,
        output pubTgl,
        input pubAck,
        input rdTgl,
        input wrTgl,
        input wrData
    );
endinterface
`default_nettype wire

/* File: verilog/pqs_mdio_slave.sv */
// serial management frame slave on the management clock
`timescale 1ns/100ps
`default_nettype none
module pqs_mdio_slave
    import pqs_pkg::*;
(
    input wire logic mgmtClk,
    input wire logic sys_rst,
    input wire logic mdioIn,
    output logic mdioOut,
    output logic mdioOeN,
    pqs_mgmt_if.mgmt m
);
    typedef struct packed {
        pqs_mdio_e st;
        logic [4:0] cnt;
        logic prev;
        logic [11:0] hdr;
        logic [15:0] sh;
        logic rdHit;
        logic wrHit;
        logic out;
        logic oeN;
        logic [1:0] pubSync;
        logic ack;
        logic [15:0] copy;
        logic rdTgl;
        logic wrTgl;
        logic [15:0] wrData;
    } pqs_mdio_s;

    localparam pqs_mdio_s MD_RST = '{st: MD_IDLE, prev: 1'b1, oeN: 1'b1, default: '0};

    pqs_mdio_s q;
    pqs_mdio_s d;

    // ---------------------------------------------------------------
    // frame walk
    // ---------------------------------------------------------------
    always_comb begin
        d = q;
        d.pubSync = {q.pubSync[0], m.pubTgl};
        // refresh the local copy once the published word is stable
        if (q.pubSync[1] != q.ack) begin
            d.copy = m.pubData;
            d.ack = q.pubSync[1];
        end
        d.prev = mdioIn;
        case (q.st)
            MD_IDLE: begin
                d.oeN = 1'b1;
                if (!q.prev && mdioIn) begin
                    d.st = MD_HDR;
                    d.cnt = '0;
                end
            end
            MD_HDR: begin
                d.hdr = {q.hdr[10:0], mdioIn};
                d.cnt = q.cnt + 5'h01;
                if (q.cnt == HDR_LAST) begin
                    d.st = MD_TURN;
                    d.cnt = '0;
                    d.rdHit = d.hdr[11:10] == OP_READ && d.hdr[9:5] == PHY_ADDR
                        && d.hdr[4:0] == REG_OFF;
                    d.wrHit = d.hdr[11:10] == OP_WRITE && d.hdr[9:5] == PHY_ADDR
                        && d.hdr[4:0] == REG_OFF;
                    if (d.rdHit) begin
                        d.sh = q.copy;
                        d.rdTgl = ~q.rdTgl;
                    end
                end
            end
            MD_TURN: begin
                d.cnt = q.cnt + 5'h01;
                if (q.rdHit) begin
                    d.oeN = 1'b0;
                    d.out = (q.cnt == '0) ? 1'b0 : q.sh[15];
                end
                if (q.cnt == TURN_LAST) begin
                    d.st = MD_DATA;
                    d.cnt = '0;
                    if (q.rdHit) begin
                        d.sh = {q.sh[14:0], mdioIn};
                    end
                end
            end
            MD_DATA: begin
                d.cnt = q.cnt + 5'h01;
                d.sh = {q.sh[14:0], mdioIn};
                d.out = q.sh[15];
                if (q.cnt == DATA_LAST) begin
                    d.st = MD_IDLE;
                    d.oeN = 1'b1;
                    d.prev = 1'b1;
                    if (q.wrHit) begin
                        d.wrData = d.sh;
                        d.wrTgl = ~q.wrTgl;
                    end
                end
            end
            default: d.st = MD_IDLE;
        endcase
    end

    always_ff @(posedge mgmtClk or posedge sys_rst) begin
        if (sys_rst) begin
            q <= MD_RST;
        end else begin
            q <= d;
        end
    end

    assign mdioOut = q.out;
    assign mdioOeN = q.oeN;
    assign m.pubAck = q.ack;
    assign m.rdTgl = q.rdTgl;
    assign m.wrTgl = q.wrTgl;
    assign m.wrData = q.wrData;

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    default clocking cb @(posedge mgmtClk); endclocking
    default disable iff (sys_rst);

    a_turn_drive_low: assert property (
        q.st == MD_TURN && q.rdHit && q.cnt == '0 |=> !mdioOeN && !mdioOut
    ) else $error("read turnaround not driven low");
endmodule // pqs_mdio_slave
`default_nettype wire

/* File: test/pqs_sta_model.sv */
// station management model: makes the management clock and works the data wire
`timescale 1ns/100ps
`default_nettype none
module pqs_sta_model
    import pqs_pkg::*;
(
    output logic mgmtClk,
    output logic mdioIn,
    input wire logic mdioOut,
    input wire logic mdioOeN
);
    logic stEn;
    logic stDrv;
    logic smp;
    logic sawDrv;

    // wire is pulled up while nobody drives it
    assign mdioIn = (mdioOeN === 1'b0) ? mdioOut : (stEn ? stDrv : 1'b1);

    initial begin
        mgmtClk = 1'b0;
        stEn = 1'b0;
        stDrv = 1'b1;
        smp = 1'b1;
        sawDrv = 1'b0;
    end

    // one bit time; clock stands low between frames
    task automatic tick();
        #7.5;
        mgmtClk = 1'b1;
        #7.5;
        smp = mdioIn;
        sawDrv = sawDrv | (mdioOeN === 1'b0);
        mgmtClk = 1'b0;
    endtask

    task automatic xfer(input logic [1:0] op, input logic [4:0] pa, input logic [4:0] ra,
                        input logic [15:0] wd, output logic [15:0] rd, output logic ta,
                        output logic drv);
        logic [45:0] hdr;
        logic [17:0] wf;
        // frame addressed by phy and register fields
        hdr = {32'hffffffff, 2'b01, op, pa, ra};
        wf = {2'b10, wd};
        rd = 16'h0000;
        ta = 1'b0;
        sawDrv = 1'b0;
        stEn = 1'b1;
        for (int i = 45; i >= 0; i--) begin
            stDrv = hdr[i];
            tick();
        end
        if (op == OP_READ) begin
            stEn = 1'b0;
            tick();
            ta = (smp === 1'b0);
            for (int i = 15; i >= 0; i--) begin
                tick();
                rd[i] = smp;
            end
            tick();
        end else begin
            for (int i = 17; i >= 0; i--) begin
                stDrv = wf[i];
                tick();
            end
        end
        stEn = 1'b0;
        drv = sawDrv;
    endtask
endmodule // pqs_sta_model
`default_nettype wire

/* File: test/pqs_quick_status_tb.sv */
// testbench of the quick-status register block
`timescale 1ns/100ps
`default_nettype none
module pqs_quick_status_tb
    import pqs_pkg::*;
;
    logic ref_clk;
    logic sys_rst;
    wire logic mgmtClk;
    wire logic mdioIn;
    wire logic mdioOut;
    wire logic mdioOeN;
    logic [4:0] evs;
    logic linkValid;
    logic partnerPause;
    logic fastSpeed;
    logic fullDuplex;
    logic [2:0] anegState;
    wire logic statusIrq;
    int failures = 0;
    int comparisons = 0;

    pqs_quick_status DUT (
        .ref_clk(ref_clk), .sys_rst(sys_rst), .mgmtClk(mgmtClk), .mdioIn(mdioIn),
        .mdioOut(mdioOut), .mdioOeN(mdioOeN), .rxErrEv(evs[0]),
        .falseCarrierEv(evs[1]), .remoteFaultEv(evs[2]), .unlockEv(evs[3]),
        .jabberEv(evs[4]), .linkValid(linkValid), .partnerPause(partnerPause),
        .fastSpeed(fastSpeed), .fullDuplex(fullDuplex), .anegState(anegState),
        .statusIrq(statusIrq)
    );

    pqs_sta_model sta (
        .mgmtClk(mgmtClk), .mdioIn(mdioIn), .mdioOut(mdioOut), .mdioOeN(mdioOeN)
    );

    // ---------------------------------------------------------------
    // shared tasks
    // ---------------------------------------------------------------
    task automatic close_out();
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        comparisons++;
        if (got !== exp) begin
            $display("unexpected %s expected %h seen %h", nm, exp, got);
            failures++;
        end
    endtask

    task automatic idle(input int n);
        repeat (n) @(negedge ref_clk);
    endtask

    task automatic ev(input int i);
        @(negedge ref_clk);
        evs[i] = 1'b1;
        @(negedge ref_clk);
        evs = 5'h00;
    endtask

    task automatic irq_is(input logic exp);
        int n;
        n = 0;
        while (statusIrq !== exp && n < 8) begin
            @(negedge ref_clk);
            n++;
        end
        chk("status irq", {15'h0000, exp}, {15'h0000, statusIrq});
        if (statusIrq !== exp) close_out();
    endtask

    task automatic rd(input logic [15:0] exp);
        logic [15:0] v;
        logic ta;
        logic d;
        sta.xfer(OP_READ, PHY_ADDR, REG_OFF, 16'h0000, v, ta, d);
        chk("read word", exp, v);
        chk("turnaround", 16'h0001, {15'h0000, ta});
        chk("release", 16'h0001, {15'h0000, mdioOeN});
        idle(10);
    endtask

    task automatic wr(input logic [4:0] pa, input logic [15:0] val);
        logic [15:0] v;
        logic ta;
        logic d;
        sta.xfer(OP_WRITE, pa, REG_OFF, val, v, ta, d);
        chk("write drive", 16'h0000, {15'h0000, d});
        idle(10);
    endtask

    task automatic link_drop();
        linkValid = 1'b0;
        idle(3);
        linkValid = 1'b1;
    endtask

    // ---------------------------------------------------------------
    // clock, watchdog and sequence
    // ---------------------------------------------------------------
    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end

    initial begin
        #500000;
        failures++;
        close_out();
    end

    initial begin
        logic [15:0] v;
        logic ta;
        logic d;
        sys_rst = 1'b1;
        evs = 5'h00;
        linkValid = 1'b0;
        partnerPause = 1'b0;
        fastSpeed = 1'b0;
        fullDuplex = 1'b0;
        anegState = ANEG_ENABLE;
        idle(8);
        sys_rst = 1'b0;
        idle(10);
        rd(16'h0000);
        linkValid = 1'b1;
        partnerPause = 1'b1;
        fastSpeed = 1'b1;
        fullDuplex = 1'b1;
        anegState = ANEG_ACK_DETECT;
        idle(12);
        rd(16'h0703);
        rd(16'h0f1b);
        sta.xfer(OP_READ, PHY_ADDR, REG_OFF - 5'h01, 16'h0000, v, ta, d);
        chk("other register drive", 16'h0000, {15'h0000, d});
        idle(10);
        wr(PHY_ADDR + 5'h01, 16'h00c0);
        rd(16'h0f1b);
        for (int i = 0; i < 8; i++) begin
            anegState = i[2:0];
            idle(2);
        end
        anegState = ANEG_COMPLETE_ACK;
        idle(12);
        rd(16'h0f07);
        rd(16'h0f24);
        for (int i = 0; i < 4; i++) begin
            ev(i);
            irq_is(1'b1);
            idle(12);
            rd(16'h0f24 | (16'h8000 >> i));
            irq_is(1'b0);
        end
        fastSpeed = 1'b0;
        idle(12);
        ev(0);
        ev(1);
        ev(3);
        idle(6);
        irq_is(1'b0);
        idle(6);
        rd(16'h0d24);
        ev(4);
        irq_is(1'b1);
        idle(12);
        rd(16'h1d24);
        fastSpeed = 1'b1;
        idle(12);
        link_drop();
        irq_is(1'b1);
        idle(12);
        rd(16'h0724);
        rd(16'h0f24);
        wr(PHY_ADDR, 16'hff40);
        rd(16'h0f64);
        ev(0);
        idle(6);
        irq_is(1'b0);
        idle(6);
        rd(16'h8f64);
        wr(PHY_ADDR, 16'h0080);
        rd(16'h0fa4);
        ev(0);
        ev(1);
        idle(6);
        irq_is(1'b0);
        link_drop();
        irq_is(1'b1);
        idle(12);
        rd(16'hc7a4);
        partnerPause = 1'b0;
        idle(12);
        rd(16'h4ba4);
        irq_is(1'b0);
        fullDuplex = 1'b0;
        idle(12);
        rd(16'h0aa4);
        close_out();
    end
endmodule // pqs_quick_status_tb
`default_nettype wire
